// ==== logic/shift_pkg.sv ====
/*
 * constants for the parallel-load shift register.
 * assumes one 250 MHz clock and inputs synchronous to it.
 */
package shift_pkg;
	localparam int STAGES      = 8;
	localparam int BUF_DEPTH   = 2;
	localparam int CLK_PERIOD_NS = 4;
endpackage

// ==== logic/skid_buffer.sv ====
/*
 * two-entry valid/ready buffer carrying one serial bit plus its complement.
 * assumes a single clock and synchronous active-high reset.
 */
module skid_buffer
	import shift_pkg::*;
#(
	parameter int WIDTH = 2,
	parameter int DEPTH = BUF_DEPTH
)
(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             srst,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PW-1:0]    wr_reg;
	logic [PW-1:0]    rd_reg;
	logic [PW:0]      cnt_reg;
	wire              push;
	wire              pop;

	assign in_ready  = (cnt_reg != (PW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_reg[rd_reg];

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end
		else
		begin
			if (push)
				wr_reg <= (wr_reg == PW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
			if (pop)
				rd_reg <= (rd_reg == PW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
			cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	always_ff @(posedge clk)
	begin
		if (push)
			mem_reg[wr_reg] <= in_data;
	end

	fill_bound_a: assert property (@(posedge clk) disable iff (srst)
		cnt_reg <= (PW+1)'(DEPTH))
		else $error("buffer count above depth");
endmodule

// ==== logic/parallel_load_shift_register.sv ====
/*
 * eight-stage parallel-in serial-out shift register with clock inhibit,
 * followed by a two-entry buffer that carries the serial output after each shift and each load made while not stalled.
 * assumes all pins are sampled synchronously on clk; edges on the shift
 * clock and inhibit are detected against their previous sampled level.
 *
 */
module parallel_load_shift_register
	import shift_pkg::*;
#(
	parameter int WIDTH = STAGES
)
(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             srst,
	// device pins
	input  wire logic             shift_or_load_n,
	input  wire logic             shift_clock,
	input  wire logic             clock_inhibit,
	input  wire logic             serial_in,
	input  wire logic [WIDTH-1:0] parallel_in,
	output logic                  serial_out,
	output logic                  serial_out_inverted,
	// buffered stream of serial output after each shift and each load made while not stalled
	output logic                  bit_valid,
	input  wire logic             bit_ready,
	output logic                  bit_data,
	output logic                  bit_data_n
);
	// ----------------------------------------
	// edge detection and mode decode
	// ----------------------------------------
	logic [WIDTH-1:0] stage_reg;
	logic [WIDTH-1:0] stage_next;
	logic             clk_prev_reg;
	logic             inh_prev_reg;
	wire              clk_rise;
	wire              inh_rise;
	wire              do_load;
	wire              do_shift;
	wire              stall;
	wire              buf_ready;
	wire [1:0]        buf_out;
	logic             push_reg;

	assign clk_rise = shift_clock && !clk_prev_reg;
	assign inh_rise = clock_inhibit && !inh_prev_reg;
	// a shift waits while the buffer is full or a push is still pending (a load does not);
	// the push lands one cycle late, so testing fullness alone could drop a word
	assign stall    = !buf_ready || push_reg;
	assign do_load  = !shift_or_load_n;
	assign do_shift = shift_or_load_n && !stall &&
		((clk_rise && !clock_inhibit) ||
		 (inh_rise && !shift_clock));
	// stage A is the lsb, stage H the msb
	assign stage_next = do_load ? parallel_in :
		do_shift ? {stage_reg[WIDTH-2:0], serial_in} :
		stage_reg;

	// ----------------------------------------
	// stage chain
	// ----------------------------------------
	// stages have no reset, as the part has none; in this chain only the edge trackers do
	always_ff @(posedge clk)
	begin
		stage_reg <= stage_next;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			// high, so a pin already high at release is not taken as a rise
			clk_prev_reg <= 1'b1;
			inh_prev_reg <= 1'b1;
		end
		else if (!stall)
		begin
			clk_prev_reg <= shift_clock;
			inh_prev_reg <= clock_inhibit;
		end
	end

	assign serial_out          = stage_reg[WIDTH-1];
	assign serial_out_inverted = ~stage_reg[WIDTH-1];

	// ----------------------------------------
	// fill tracking for the checks
	// ----------------------------------------
	// the stages power up unknown; checks trust them only after a load or a
	// full run of shifts. a reset forgets this although the stages keep their
	// contents, which only makes the checks more cautious
	localparam int FW = $clog2(WIDTH + 1);

	logic [FW-1:0] fill_reg;
	wire           filled;

	assign filled = (fill_reg == FW'(WIDTH));

	always_ff @(posedge clk)
	begin
		if (srst)
			fill_reg <= '0;
		else if (do_load)
			fill_reg <= FW'(WIDTH);
		else if (do_shift && !filled)
			fill_reg <= fill_reg + 1'b1;
	end

	// ----------------------------------------
	// output buffer
	// ----------------------------------------
	// each shift, and each load made while not stalled, hands on one word a cycle later, once stage_reg is new
	always_ff @(posedge clk)
	begin
		if (srst)
			push_reg <= 1'b0;
		else
			push_reg <= do_shift || (do_load && !stall);
	end

	// both outputs travel in one word so the consumer sees them in step
	skid_buffer #(
		.WIDTH (2),
		.DEPTH (BUF_DEPTH)
	) u_buf (
		.clk       (clk),
		.srst      (srst),
		.in_valid  (push_reg),
		.in_ready  (buf_ready),
		.in_data   ({stage_reg[WIDTH-1], ~stage_reg[WIDTH-1]}),
		.out_valid (bit_valid),
		.out_ready (bit_ready),
		.out_data  (buf_out)
	);

	assign bit_data   = buf_out[1];
	assign bit_data_n = buf_out[0];

	// ----------------------------------------
	// checks
	// ----------------------------------------
	load_copies_a: assert property (@(posedge clk) disable iff (srst)
		!shift_or_load_n |=> stage_reg == $past(parallel_in))
		else $error("load did not copy parallel inputs");

	shift_moves_a: assert property (@(posedge clk) disable iff (srst)
		do_shift |=> stage_reg[WIDTH-1:1] == $past(stage_reg[WIDTH-2:0]))
		else $error("stages did not move on shift");

	serial_enters_a: assert property (@(posedge clk) disable iff (srst)
		do_shift |=> stage_reg[0] == $past(serial_in))
		else $error("serial input not captured");

	// the rise checks look at the raw pin history, not at the edge trackers;
	// the stability and output pair checks wait for filled, as the stages power up unknown
	clock_rise_a: assert property (@(posedge clk) disable iff (srst)
		shift_or_load_n && shift_clock && !$past(shift_clock) && !clock_inhibit
		&& !stall && !$past(stall) && !$past(srst) |-> do_shift)
		else $error("clock rise did not shift");

	inhibit_rise_a: assert property (@(posedge clk) disable iff (srst)
		shift_or_load_n && clock_inhibit && !$past(clock_inhibit) && !shift_clock
		&& !stall && !$past(stall) && !$past(srst) |-> do_shift)
		else $error("inhibit rise did not shift");

	clock_blocked_a: assert property (@(posedge clk) disable iff (srst)
		shift_or_load_n && clk_rise && clock_inhibit |-> !do_shift)
		else $error("clock rise shifted with inhibit high");

	held_high_a: assert property (@(posedge clk) disable iff (srst)
		filled && shift_or_load_n && $past(shift_clock) && shift_clock && $past(!stall)
		|=> $stable(stage_reg))
		else $error("stages changed with clock held high");

	inhibit_held_a: assert property (@(posedge clk) disable iff (srst)
		filled && shift_or_load_n && $past(clock_inhibit) && clock_inhibit
		&& $past(!stall) |=> $stable(stage_reg))
		else $error("stages changed with inhibit held high");

	load_blocked_a: assert property (@(posedge clk) disable iff (srst)
		filled && shift_or_load_n && !do_shift |=> $stable(stage_reg))
		else $error("stages changed with load high and no shift");

	stall_holds_a: assert property (@(posedge clk) disable iff (srst)
		filled && shift_or_load_n && stall |=> $stable(stage_reg))
		else $error("stages changed while the buffer stalled");

	load_wins_a: assert property (@(posedge clk) disable iff (srst)
		!shift_or_load_n && (clk_rise || inh_rise) |=> stage_reg == $past(parallel_in))
		else $error("edge disturbed a parallel load");

	output_pair_a: assert property (@(posedge clk) disable iff (srst)
		filled |-> serial_out != serial_out_inverted && serial_out == stage_reg[WIDTH-1])
		else $error("serial outputs not complementary");

	push_kept_a: assert property (@(posedge clk) disable iff (srst)
		push_reg |-> buf_ready)
		else $error("buffer push met a full buffer");

	chain_fills_a: assert property (@(posedge clk) disable iff (srst)
		!filled && do_shift |=> fill_reg == $past(fill_reg) + 1'b1)
		else $error("fill count missed a shift");

	fill_limit_a: assert property (@(posedge clk) disable iff (srst)
		fill_reg <= FW'(WIDTH))
		else $error("fill count beyond stage count");
endmodule

// ==== verification/controller_model.sv ====
/*
 * controller model: loads the register, then clocks it out.
 * assumes one clk; tasks are entered just after its rising edge.
 */
module controller_model
(
	// clock
	input  wire logic  clk,
	// register pins
	output logic       shift_or_load_n = 1'b1,
	output logic       shift_clock = 1'b0,
	output logic       clock_inhibit = 1'b0,
	output logic       serial_in = 1'b0,
	output logic [7:0] parallel_in = 8'h00
);
	timeunit 1ns;
	timeprecision 1ps;

	// each level holds n edges, so an edge outlasts a short buffer stall
	task automatic pins(input logic sl, input logic ck, input logic ih, input int n);
		shift_or_load_n <= sl;
		shift_clock     <= ck;
		clock_inhibit   <= ih;
		repeat (n) @(posedge clk);
	endtask

	task automatic load(input logic [7:0] p);
		parallel_in <= p;
		serial_in   <= 1'($urandom);
		pins(1'b0, 1'($urandom), 1'($urandom), 1);
		parallel_in <= ~p;
		pins(1'b1, 1'b0, 1'b0, 5);
	endtask

	task automatic shift(input logic s, input logic by_inh);
		serial_in <= s;
		pins(1'b1, !by_inh, by_inh, 5);
		pins(1'b1, 1'b1, 1'b1, 5);
		pins(1'b1, 1'b1, 1'b0, 5);
		pins(1'b1, 1'b0, 1'b0, 5);
	endtask
endmodule

// ==== verification/parallel_load_shift_register_bench.sv ====
/*
 * random loads and shifts, buffered bits checked against a stage model.
 * assumes the package, design and controller model are compiled first.
 */
`define CHK(a, b) \
	begin \
		comparisons++; \
		if ((a) !== (b)) \
		begin \
			fails++; \
			$display("BAD t=%0t got %h exp %h", $time, (a), (b)); \
		end \
	end
module parallel_load_shift_register_bench
	import shift_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic              clk = 1'b0;
	logic              srst = 1'b1;
	logic              bit_ready = 1'b1;
	logic              hold = 1'b1;
	wire logic         shift_or_load_n, shift_clock, clock_inhibit, serial_in;
	wire logic [7:0]   parallel_in;
	logic              serial_out, serial_out_inverted, bit_valid, bit_data, bit_data_n;
	logic [STAGES-1:0] st;
	logic              q[$];
	logic              e;
	logic              s;
	int                fails = 0;
	int                comparisons = 0;
	int                low = 0;

	controller_model ctl (.clk, .shift_or_load_n, .shift_clock, .clock_inhibit,
		.serial_in, .parallel_in);
	parallel_load_shift_register DUT (.clk, .srst, .shift_or_load_n, .shift_clock,
		.clock_inhibit, .serial_in, .parallel_in, .serial_out, .serial_out_inverted,
		.bit_valid, .bit_ready, .bit_data, .bit_data_n);

	initial
		forever #(CLK_PERIOD_NS / 2.0) clk = ~clk;

	// stalls last two cycles at most, so a held-off edge is still there
	always @(posedge clk)
	begin
		low = bit_ready ? 0 : low + 1;
		bit_ready <= hold || low >= 2 || 1'($urandom);
	end

	always @(posedge clk)
		if (!srst && bit_valid && bit_ready)
		begin
			`CHK(q.size() > 0, 1'b1)
			e = q.size() > 0 ? q.pop_front() : 1'bx;
			`CHK(bit_data, e)
			`CHK(bit_data_n, ~e)
		end

	task automatic test_done();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		void'($urandom(30424));
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		`CHK(bit_valid, 1'b0)
		for (int r = 0; r < 12; r++)
		begin
			st = r == 0 ? 8'h00 : r == 1 ? 8'hff : 8'($urandom);
			hold <= 1'b1;
			repeat (3) @(posedge clk);
			q.push_back(st[7]);
			ctl.load(st);
			hold <= 1'b0;
			for (int i = 0; i < 8 + r % 3; i++)
			begin
				s = 1'($urandom);
				st = {st[6:0], s};
				q.push_back(st[7]);
				ctl.shift(s, 1'($urandom));
			end
			hold <= 1'b1;
			for (int w = 0; q.size() > 0; w++)
			begin
				if (w > 50)
				begin
					fails++;
					test_done();
				end
				@(posedge clk);
			end
			`CHK({serial_out, serial_out_inverted}, {st[7], ~st[7]})
			// a mid-run reset empties the buffer but leaves the stages alone
			if (r == 5)
			begin
				srst <= 1'b1;
				repeat (2) @(posedge clk);
				srst <= 1'b0;
				@(posedge clk);
				`CHK(bit_valid, 1'b0)
				`CHK(serial_out, st[7])
			end
		end
		test_done();
	end
endmodule
